// *** verilog/carrier_timer_pkg.sv ***
/*
  constants and bus carrier types for the carrier timer pair.
  assumes an 8-bit register port, one 25 MHz clock, synchronous reset.
*/
package carrier_timer_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] BYTE_CTL_OFS = 8'h00;   // byte_timer_control
  localparam logic [7:0] SHARED_CTL_OFS = 8'h01; // shared_timer_control
  localparam logic [7:0] WIDE_CTL_OFS = 8'h02;   // wide_timer_control
  localparam logic [7:0] BYTE_LO_OFS = 8'h04;    // byte_timer_low_hold
  localparam logic [7:0] BYTE_HI_OFS = 8'h05;    // byte_timer_high_hold
  localparam logic [7:0] WIDE_LO_OFS = 8'h06;    // wide_timer_low_hold
  localparam logic [7:0] WIDE_HI_OFS = 8'h07;    // wide_timer_high_hold
  localparam logic [7:0] CAP_LO_OFS = 8'h08;     // captured count, low byte
  localparam logic [7:0] CAP_HI_OFS = 8'h09;     // captured count, high byte
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0A;   // sticky status, read only
  localparam logic [7:0] IRQ_EN_OFS = 8'h0B;     // interrupt enable
  localparam logic [7:0] IRQ_CLR_OFS = 8'h0C;    // write one to clear
  // ==========================================================
  // field positions, timer control registers
  localparam int EN_BIT = 7;       // enable / running
  localparam int MODE_BIT = 6;     // single pass or edge ignore
  localparam int FLAG_BIT = 5;     // timeout flag
  localparam int CLK_LO = 3;       // prescale select low bit
  localparam int CAPM_BIT = 2;     // capture interrupt mask
  localparam int TOM_BIT = 1;      // timeout interrupt mask
  localparam int PIN_BIT = 0;      // route output to pin
  // shared control fields
  localparam int DEMOD_BIT = 7;    // 1 = demodulation, 0 = transmit
  localparam int EDGE_LO = 4;      // bit4 rising, bit5 falling
  localparam int ALT_LO = 2;       // alternating select, bits 3:2
  localparam int BYTE_INIT_BIT = 1;
  localparam int WIDE_INIT_BIT = 0;
  // status bits
  localparam int ST_BYTE_TO = 0;
  localparam int ST_WIDE_TO = 1;
  localparam int ST_WIDE_CAP = 2;
  localparam int ST_W = 3;
  // ==========================================================
  // reset values and masks
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] CTL_STORE = 8'h5F;  // bits 7 and 5 live elsewhere
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] WIDE_RST = 16'h0000;
  localparam logic [15:0] WIDE_WRAP = 16'hFFFF;
  localparam logic [2:0] DIV_RST = 3'h0;

  // register port request
  typedef struct packed {
    logic wr;          // write strobe
    logic rd;          // read strobe
    logic [7:0] addr;  // register offset
    logic [7:0] wdata; // write data
  } bus_req_s;
endpackage

// *** verilog/carrier_timer_pair.sv ***
/*
  carrier timer pair: byte timer and wide timer, demodulation
  capture and alternating transmit sequencing, with register port.
  assumes all inputs synchronous to clk; reads answer one cycle later.
*/
// Our own choice: the address-and-strobe port.
module carrier_timer_pair (
  input wire logic clk,                              // 25 MHz clock
  input wire logic rst_n,                            // sync reset
  input wire carrier_timer_pkg::bus_req_s bus_req,   // register request
  input wire logic carrier_in,                       // modulated carrier
  input wire logic [1:0] port_level,                 // port data, pins
  output logic [7:0] rd_data,                        // read data
  output logic byte_timer_pin,                       // byte pin level
  output logic wide_timer_pin,                       // wide pin level
  output logic irq                                   // level interrupt
);
  import carrier_timer_pkg::*;

  // ==========================================================
  // registers
  logic [7:0] byte_ctl_r;    // byte control, stored bits
  logic [7:0] shared_ctl_r;  // shared control
  logic [7:0] wide_ctl_r;    // wide control, stored bits
  logic [7:0] byte_lo_r;     // byte low hold
  logic [7:0] byte_hi_r;     // byte high hold
  logic [7:0] wide_lo_r;     // wide low hold
  logic [7:0] wide_hi_r;     // wide high hold
  logic [ST_W-1:0] stat_r;   // sticky status
  logic [ST_W-1:0] irq_en_r; // interrupt enable
  logic byte_flag_r;         // byte timeout flag
  logic wide_flag_r;         // wide timeout flag
  logic byte_en_r;           // byte running
  logic wide_en_r;           // wide running
  logic byte_out_r;          // byte output level
  logic wide_out_r;          // wide output level
  logic [7:0] byte_cnt_r;    // byte count
  logic [15:0] wide_cnt_r;   // wide count
  logic [15:0] cap_r;        // captured wide count
  logic armed_r;             // one capture-reload pending
  logic carrier_prev_r;      // carrier one cycle ago
  logic [2:0] div_r;         // free prescaler

  // ==========================================================
  // decodes
  function automatic logic hit(input logic [7:0] ofs);
    hit = bus_req.wr && (bus_req.addr == ofs);
  endfunction

  // divide by 1,2,4,8 as a one-cycle enable
  function automatic logic tick_of(input logic [1:0] sel);
    if (sel == 2'h0) begin
      tick_of = 1'b1;
    end else if (sel == 2'h1) begin
      tick_of = div_r[0];
    end else if (sel == 2'h2) begin
      tick_of = &div_r[1:0];
    end else begin
      tick_of = &div_r;
    end
  endfunction

  logic demod;       // demodulation mode
  logic alt;         // alternating operation active
  logic byte_tick;   // byte prescaled enable
  logic wide_tick;   // wide prescaled enable
  logic byte_tc;     // byte terminal count
  logic wide_tc;     // wide zero reached
  logic qual_edge;   // selected carrier edge
  logic ign;         // edge ignore selected
  logic edge_cap;    // edge capture and reload
  logic to_cap;      // timeout capture, no reload
  logic byte_start;  // byte timer starts
  logic wide_start;  // wide timer starts
  logic byte_stop;   // software stops byte
  logic wide_stop;   // software stops wide
  logic [7:0] byte_load;   // hold chosen by level

  assign demod = shared_ctl_r[DEMOD_BIT];
  // any nonzero select runs alternating, zero stops it
  assign alt = !demod && (shared_ctl_r[ALT_LO+1:ALT_LO] != 2'h0);
  assign byte_tick = tick_of(byte_ctl_r[CLK_LO+1:CLK_LO]);
  assign wide_tick = tick_of(wide_ctl_r[CLK_LO+1:CLK_LO]);
  assign byte_tc = byte_en_r && byte_tick && (byte_cnt_r == 8'h00);
  assign wide_tc = wide_en_r && wide_tick && (wide_cnt_r == 16'h0000);
  assign qual_edge = (shared_ctl_r[EDGE_LO] && carrier_in && !carrier_prev_r)
    || (shared_ctl_r[EDGE_LO+1] && !carrier_in && carrier_prev_r);
  assign ign = wide_ctl_r[MODE_BIT];
  // edges count only when recognised or a single one is armed
  assign edge_cap = demod && wide_en_r && qual_edge && (!ign || armed_r);
  assign to_cap = demod && wide_en_r && ign && byte_tc && !edge_cap;
  assign byte_stop = hit(BYTE_CTL_OFS) && !bus_req.wdata[EN_BIT];
  assign wide_stop = hit(WIDE_CTL_OFS) && !bus_req.wdata[EN_BIT];
  // software enable, or the wide timer handing back
  assign byte_start = (hit(BYTE_CTL_OFS) && bus_req.wdata[EN_BIT])
    || (alt && wide_tc && !byte_stop);
  assign wide_start = (hit(WIDE_CTL_OFS) && bus_req.wdata[EN_BIT])
    || (alt && byte_tc && !wide_stop);
  assign byte_load = shared_ctl_r[BYTE_INIT_BIT] ? byte_hi_r : byte_lo_r;

  // ==========================================================
  // prescaler: one counter shared by both timers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_r <= DIV_RST;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // carrier history for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      carrier_prev_r <= 1'b0;
    end else begin
      carrier_prev_r <= carrier_in;
    end
  end

  // ==========================================================
  // plain control and hold registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byte_ctl_r <= CTL_RST;
      shared_ctl_r <= CTL_RST;
      wide_ctl_r <= CTL_RST;
      byte_lo_r <= BYTE_RST;
      byte_hi_r <= BYTE_RST;
      wide_lo_r <= BYTE_RST;
      wide_hi_r <= BYTE_RST;
      irq_en_r <= '0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == BYTE_CTL_OFS) begin
        byte_ctl_r <= bus_req.wdata & CTL_STORE;
      end else if (bus_req.addr == SHARED_CTL_OFS) begin
        shared_ctl_r <= bus_req.wdata;
      end else if (bus_req.addr == WIDE_CTL_OFS) begin
        wide_ctl_r <= bus_req.wdata & CTL_STORE;
      end else if (bus_req.addr == BYTE_LO_OFS) begin
        byte_lo_r <= bus_req.wdata;
      end else if (bus_req.addr == BYTE_HI_OFS) begin
        byte_hi_r <= bus_req.wdata;
      end else if (bus_req.addr == WIDE_LO_OFS) begin
        wide_lo_r <= bus_req.wdata;
      end else if (bus_req.addr == WIDE_HI_OFS) begin
        wide_hi_r <= bus_req.wdata;
      end else if (bus_req.addr == IRQ_EN_OFS) begin
        irq_en_r <= bus_req.wdata[ST_W-1:0];
      end
    end
  end

  // arming: a 0 then 1 write of the ignore bit allows one edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (hit(WIDE_CTL_OFS) && bus_req.wdata[MODE_BIT] && !ign) begin
      armed_r <= 1'b1;
    end else if (edge_cap) begin
      armed_r <= 1'b0;
    end
  end

  // ==========================================================
  // byte timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byte_en_r <= 1'b0;
      byte_out_r <= 1'b0;
      byte_cnt_r <= BYTE_RST;
    end else if (byte_stop) begin
      byte_en_r <= 1'b0;
    end else if (byte_start) begin
      byte_en_r <= 1'b1;
      byte_out_r <= shared_ctl_r[BYTE_INIT_BIT];
      byte_cnt_r <= byte_load;
    end else if (byte_tc) begin
      byte_out_r <= !byte_out_r;
      // alternating or single pass stops; modulo-N reloads
      if (alt || byte_ctl_r[MODE_BIT]) begin
        byte_en_r <= 1'b0;
      end else begin
        byte_cnt_r <= byte_out_r ? byte_lo_r : byte_hi_r;
      end
    end else if (byte_en_r && byte_tick) begin
      byte_cnt_r <= byte_cnt_r - 8'h01;
    end
  end

  // ==========================================================
  // wide timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wide_en_r <= 1'b0;
      wide_out_r <= 1'b0;
      wide_cnt_r <= WIDE_RST;
    end else if (wide_stop) begin
      wide_en_r <= 1'b0;
    end else if (wide_start) begin
      wide_en_r <= 1'b1;
      wide_out_r <= shared_ctl_r[WIDE_INIT_BIT];
      wide_cnt_r <= {wide_hi_r, wide_lo_r};
    end else if (edge_cap) begin
      wide_cnt_r <= {wide_hi_r, wide_lo_r};
    end else if (demod) begin
      // demodulation never stops at zero: it wraps, which is 0 - 1
      if (wide_en_r && wide_tick) begin
        wide_cnt_r <= wide_cnt_r - 16'h0001;
      end
    end else if (wide_tc) begin
      wide_out_r <= !wide_out_r;
      if (alt || wide_ctl_r[MODE_BIT]) begin
        wide_en_r <= 1'b0;
      end else begin
        wide_cnt_r <= {wide_hi_r, wide_lo_r};
      end
    end else if (wide_en_r && wide_tick) begin
      wide_cnt_r <= wide_cnt_r - 16'h0001;
    end
  end

  // captured count: edge capture or byte timeout in ignore mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cap_r <= WIDE_RST;
    end else if (edge_cap || to_cap) begin
      cap_r <= wide_cnt_r;
    end
  end

  // ==========================================================
  // timeout flags: the hardware set wins over a clearing write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byte_flag_r <= 1'b0;
      wide_flag_r <= 1'b0;
    end else begin
      if (byte_tc) begin
        byte_flag_r <= 1'b1;
      end else if (hit(BYTE_CTL_OFS) && bus_req.wdata[FLAG_BIT]) begin
        byte_flag_r <= 1'b0;
      end
      if (wide_tc) begin
        wide_flag_r <= 1'b1;
      end else if (hit(WIDE_CTL_OFS) && bus_req.wdata[FLAG_BIT]) begin
        wide_flag_r <= 1'b0;
      end
    end
  end

  // sticky status, gated by the masks in the control registers
  logic [ST_W-1:0] stat_set;  // events that reached status
  assign stat_set[ST_BYTE_TO] = byte_tc && byte_ctl_r[TOM_BIT];
  assign stat_set[ST_WIDE_TO] = wide_tc && wide_ctl_r[TOM_BIT];
  assign stat_set[ST_WIDE_CAP] = (edge_cap || to_cap) && wide_ctl_r[CAPM_BIT];

  generate
    for (genvar i = 0; i < ST_W; i++) begin : g_stat
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          stat_r[i] <= 1'b0;
        end else if (stat_set[i]) begin
          stat_r[i] <= 1'b1;
        end else if (hit(IRQ_CLR_OFS) && bus_req.wdata[i]) begin
          stat_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // outputs, all registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
      byte_timer_pin <= 1'b0;
      wide_timer_pin <= 1'b0;
    end else begin
      irq <= |(stat_r & irq_en_r);
      byte_timer_pin <= byte_ctl_r[PIN_BIT] ? byte_out_r : port_level[0];
      wide_timer_pin <= wide_ctl_r[PIN_BIT] ? wide_out_r : port_level[1];
    end
  end

  // read port: data in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!rst_n || !bus_req.rd) begin
      rd_data <= 8'h00;
    end else if (bus_req.addr == BYTE_CTL_OFS) begin
      rd_data <= {byte_en_r, byte_ctl_r[6], byte_flag_r, byte_ctl_r[4:0]};
    end else if (bus_req.addr == SHARED_CTL_OFS) begin
      rd_data <= shared_ctl_r;
    end else if (bus_req.addr == WIDE_CTL_OFS) begin
      rd_data <= {wide_en_r, wide_ctl_r[6], wide_flag_r, wide_ctl_r[4:0]};
    end else if (bus_req.addr == BYTE_LO_OFS) begin
      rd_data <= byte_lo_r;
    end else if (bus_req.addr == BYTE_HI_OFS) begin
      rd_data <= byte_hi_r;
    end else if (bus_req.addr == WIDE_LO_OFS) begin
      rd_data <= wide_lo_r;
    end else if (bus_req.addr == WIDE_HI_OFS) begin
      rd_data <= wide_hi_r;
    end else if (bus_req.addr == CAP_LO_OFS) begin
      rd_data <= cap_r[7:0];
    end else if (bus_req.addr == CAP_HI_OFS) begin
      rd_data <= cap_r[15:8];
    end else if (bus_req.addr == IRQ_STAT_OFS) begin
      rd_data <= {5'h00, stat_r};
    end else if (bus_req.addr == IRQ_EN_OFS) begin
      rd_data <= {5'h00, irq_en_r};
    end else begin
      rd_data <= 8'h00;
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_byte_end;
    alt && byte_tc && !bus_req.wr;
  endsequence
  sequence s_handover;
    !byte_en_r && wide_en_r && wide_cnt_r == {wide_hi_r, wide_lo_r};
  endsequence

  chk_ignore_edges: assert property (demod && ign && !armed_r && qual_edge
    && !to_cap |=> $stable(cap_r)) else $error("edge seen while ignoring");
  chk_timeout_capture: assert property (to_cap && !bus_req.wr
    |=> cap_r == $past(wide_cnt_r) && (wide_cnt_r == $past(wide_cnt_r)
    || wide_cnt_r == $past(wide_cnt_r) - 16'h0001))
    else $error("timeout capture wrong");
  chk_armed_once: assert property (armed_r && edge_cap && !bus_req.wr
    |=> !armed_r && cap_r == $past(wide_cnt_r)) else $error("armed edge missed");
  chk_wrap_flag: assert property (demod && wide_tc && !bus_req.wr && !edge_cap
    |=> wide_cnt_r == WIDE_WRAP && wide_flag_r) else $error("no wrap");
  chk_byte_handover: assert property (s_byte_end |=> s_handover
    ##0 wide_out_r == $past(shared_ctl_r[WIDE_INIT_BIT]))
    else $error("handover wrong");
  chk_wide_handback: assert property (alt && wide_tc && !bus_req.wr
    |=> !wide_en_r && byte_en_r && byte_cnt_r == byte_load)
    else $error("handback wrong");
  chk_byte_irq: assert property (byte_tc && byte_ctl_r[TOM_BIT]
    |=> stat_r[ST_BYTE_TO]) else $error("byte interrupt lost");
  chk_flag_clear: assert property (hit(WIDE_CTL_OFS)
    && bus_req.wdata[FLAG_BIT] && !wide_tc |=> !wide_flag_r)
    else $error("flag not cleared");
  chk_pin_route: assert property (wide_ctl_r[PIN_BIT] && $stable(wide_ctl_r)
    |=> wide_timer_pin == $past(wide_out_r)) else $error("pin route wrong");
endmodule

// *** tb/carrier_source.sv ***
/*
  far-side model: the modulated carrier and the port data pins.
  assumes the bench calls its tasks from the main sequence; every change
  lands by non-blocking assignment just after a rising clock edge.
*/
module carrier_source (
  input wire logic clk,          // system clock
  output logic carrier_in,       // modulated carrier level
  output logic [1:0] port_level  // port data behind the output pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // start-up levels
  // carrier idles low so that the first change seen is a rising edge
  initial begin
    carrier_in = 1'b0;
    port_level = 2'b00;
  end

  // ==========================================================
  // drive tasks
  // carrier level change, one edge per call
  task automatic set_carrier(input logic v);
    @(posedge clk);
    carrier_in <= v;
  endtask

  // port data change, seen on a pin only when the timer is not routed
  task automatic set_port(input logic [1:0] v);
    @(posedge clk);
    port_level <= v;
  endtask
endmodule

// *** tb/carrier_timer_pair_tb.sv ***
/*
  self-checking bench for the carrier timer pair: register bus tasks,
  demodulation capture, wrap, interrupts and alternating transmit.
  assumes the design answers reads one cycle later and needs no wait.
*/
module carrier_timer_pair_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import carrier_timer_pkg::*;

  // ==========================================================
  // signals
  logic clk;                 // 25 MHz clock
  logic rst_n;               // sync reset, active low
  bus_req_s bus_req;         // register request
  logic carrier_in;          // carrier from the far-side model
  logic [1:0] port_level;    // port data from the far-side model
  logic [7:0] rd_data;       // read data
  logic byte_timer_pin;      // byte output pin
  logic wide_timer_pin;      // wide output pin
  logic irq;                 // level interrupt
  int num_errors;            // mismatches seen
  int n_checks;              // comparisons made
  logic [7:0] rv;            // last read value
  logic [15:0] c1;           // first captured count
  logic [15:0] c2;           // later captured count

  // ==========================================================
  // instances
  carrier_timer_pair DUT (
    .clk(clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .carrier_in(carrier_in),
    .port_level(port_level),
    .rd_data(rd_data),
    .byte_timer_pin(byte_timer_pin),
    .wide_timer_pin(wide_timer_pin),
    .irq(irq)
  );

  carrier_source src (
    .clk(clk),
    .carrier_in(carrier_in),
    .port_level(port_level)
  );

  // ==========================================================
  // clock and time-zero values
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================
  // bus and check tasks
  // one-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
  endtask

  // read data stand only in the cycle after the strobe, sampled there
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
    #1 v = rd_data;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk({8'h00, v}, {8'h00, exp});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // no latch between the halves, so read only while the capture is quiet
  task automatic rd_cap(output logic [15:0] c);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(CAP_LO_OFS, lo);
    rd(CAP_HI_OFS, hi);
    c = {hi, lo};
  endtask

  // bounded poll on a timer enable bit; gives up after 40 reads
  task automatic poll_en(input logic [7:0] a, input logic v);
    for (int i = 0; i < 40; i++) begin
      rd(a, rv);
      if (rv[EN_BIT] === v) break;
    end
  endtask

  // ==========================================================
  // verdict, the single end of the run
  task automatic complete_run;
    if (num_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(40 * 20000);
    num_errors++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    num_errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    bus_req = '0;
    idle(2);
    rst_n <= 1'b1;
    // reset values, unmapped place, read-only status
    rd_chk(WIDE_CTL_OFS, 8'h00);
    rd_chk(8'h03, 8'h00);
    wr(IRQ_STAT_OFS, 8'h07);
    rd_chk(IRQ_STAT_OFS, 8'h00);
    // every stored field reads back; enable and flag stay clear
    wr(WIDE_CTL_OFS, 8'h5F);
    rd_chk(WIDE_CTL_OFS, 8'h5F);
    wr(WIDE_CTL_OFS, 8'h1E);
    rd_chk(WIDE_CTL_OFS, 8'h1E);
    wr(WIDE_CTL_OFS, 8'h00);
    // pin left to port data while not routed
    src.set_port(2'b10);
    idle(3);
    chk(wide_timer_pin, 1'b1);
    chk(byte_timer_pin, 1'b0);
    // opposite pattern so that a swap of the two port bits shows
    src.set_port(2'b01);
    idle(3);
    chk(wide_timer_pin, 1'b0);
    chk(byte_timer_pin, 1'b1);

    // demodulation: count 3 reaches zero and wraps to all ones
    wr(SHARED_CTL_OFS, 8'h90);
    wr(WIDE_LO_OFS, 8'h03);
    wr(WIDE_HI_OFS, 8'h00);
    wr(WIDE_CTL_OFS, 8'h82);
    idle(30);
    src.set_carrier(1'b1);
    idle(30);
    rd_cap(c1);
    chk(c1[15:8], 8'hFF);
    rd_chk(WIDE_CTL_OFS, 8'hA2);
    rd_chk(IRQ_STAT_OFS, 8'h02);
    wr(IRQ_EN_OFS, 8'h02);
    idle(3);
    chk(irq, 1'b1);
    // stop first: a running timer would wrap again and re-raise the flag
    wr(WIDE_CTL_OFS, 8'h02);
    rd_chk(WIDE_CTL_OFS, 8'h22);
    wr(WIDE_CTL_OFS, 8'h22);
    rd_chk(WIDE_CTL_OFS, 8'h02);
    wr(IRQ_CLR_OFS, 8'h02);
    idle(3);
    chk(irq, 1'b0);
    wr(WIDE_CTL_OFS, 8'h00);
    rd_chk(WIDE_CTL_OFS, 8'h00);

    // edge ignoring: one armed capture, later edges disregarded
    wr(WIDE_LO_OFS, 8'h34);
    wr(WIDE_HI_OFS, 8'h12);
    src.set_carrier(1'b0);
    wr(WIDE_CTL_OFS, 8'h84);
    wr(WIDE_CTL_OFS, 8'hC4);
    idle(10);
    src.set_carrier(1'b1);
    idle(5);
    rd(IRQ_STAT_OFS, rv);
    chk(rv[ST_WIDE_CAP], 1'b1);
    rd_cap(c1);
    src.set_carrier(1'b0);
    idle(5);
    src.set_carrier(1'b1);
    idle(5);
    rd_cap(c2);
    chk(c2, c1);
    // byte timeout captures the running count, no reload
    wr(BYTE_LO_OFS, 8'h04);
    wr(BYTE_HI_OFS, 8'h04);
    wr(BYTE_CTL_OFS, 8'hC0);
    idle(20);
    rd_cap(c2);
    chk((c2 != c1) && (c2 < 16'h1234), 1'b1);

    // quiet everything before changing mode
    wr(WIDE_CTL_OFS, 8'h20);
    wr(BYTE_CTL_OFS, 8'h20);
    wr(SHARED_CTL_OFS, 8'h00);
    wr(IRQ_CLR_OFS, 8'h07);
    // alternating transmit: both single pass, routed, timeout masks set
    wr(BYTE_LO_OFS, 8'h06);
    wr(BYTE_HI_OFS, 8'h06);
    wr(WIDE_LO_OFS, 8'h08);
    wr(WIDE_HI_OFS, 8'h00);
    wr(WIDE_CTL_OFS, 8'h43);
    wr(BYTE_CTL_OFS, 8'h43);
    wr(SHARED_CTL_OFS, 8'h07);
    wr(IRQ_EN_OFS, 8'h03);
    wr(BYTE_CTL_OFS, 8'hC3);
    idle(3);
    chk(byte_timer_pin, 1'b1);
    poll_en(WIDE_CTL_OFS, 1'b1);
    chk(rv[EN_BIT], 1'b1);
    chk(wide_timer_pin, 1'b1);
    rd(BYTE_CTL_OFS, rv);
    chk(rv[EN_BIT], 1'b0);
    poll_en(BYTE_CTL_OFS, 1'b1);
    chk(rv[EN_BIT], 1'b1);
    rd(IRQ_STAT_OFS, rv);
    chk(rv[1:0], 2'b11);
    chk(irq, 1'b1);
    // select bits to zero: no further hand-over to the wide timer
    wr(SHARED_CTL_OFS, 8'h00);
    idle(60);
    rd(WIDE_CTL_OFS, rv);
    chk(rv[EN_BIT], 1'b0);
    rd(BYTE_CTL_OFS, rv);
    chk(rv[EN_BIT], 1'b0);
    // wide modulo-N at clock/8: late first terminal count, keeps running
    wr(WIDE_LO_OFS, 8'h02);
    wr(WIDE_HI_OFS, 8'h00);
    wr(WIDE_CTL_OFS, 8'hB9);
    idle(10);
    rd_chk(WIDE_CTL_OFS, 8'h99);
    idle(40);
    rd_chk(WIDE_CTL_OFS, 8'hB9);
    complete_run();
  end
endmodule
